// ===== core/csg_gate.sv
// Operation
// - Full access only when 128-bit key equals password.
// - Flash, OTP, L0 and L1 form one region.
// - Locked: refuse debug and open-code secure reads.
// - Password reads always use 16 wait states.
// - Emulator touching secure memory cuts the link.
// - Low 64-bit match allows emulation, reads stay blocked.
// - Software dummy-reads all eight password words first.
// - Blank low password needs no low key match.
// - All-zero password keeps the device locked forever.
// - Secured: reserved range holds only zero words.
// - Unsecured: reserved data words hold no code.
// - No hold-in-reset; processor runs straight after reset.
`timescale 1ns/10ps
`include "csg_defs.svh"

module csg_gate (
   input  wire logic                   CLOCK_I,
   input  wire logic                   RST_N_I,
   csg_if.gate                         LINK,
   output logic                        FLASH_RD_O,
   output logic [`CSG_ADDR_W-1:0]      FLASH_ADDR_O,
   input  wire logic [`CSG_WORD_W-1:0] FLASH_DATA_I,
   output logic                        LOCKED_O
);
   import csg_pkg::*;

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      csg_gate_st_e              st;
      logic [`CSG_WS_W-1:0]      ws;
      logic [`CSG_IDX_W-1:0]     idx;
      logic                      rd;
      logic [`CSG_ADDR_W-1:0]    addr;
      csg_key_t                  key;
      csg_key_t                  pw;
      logic [7:0]                loaded;
      logic                      full;
      logic                      emu;
      logic                      trip;
      logic                      pw_ack;
      logic                      acc_ack;
      logic                      acc_ok;
      logic                      run;
   } csg_gate_s;

   csg_gate_s state_r;
   csg_gate_s state_nxt;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------

   // One region covers flash, the one-time area and the two low RAM blocks.
   function automatic logic in_secure(input logic [`CSG_ADDR_W-1:0] a);
      in_secure = ((a >= `CSG_FLASH_LO) && (a <= `CSG_FLASH_HI))
                || ((a >= `CSG_OTP_LO) && (a <= `CSG_OTP_HI))
                || ((a >= `CSG_L0_LO) && (a <= `CSG_L0_HI))
                || ((a >= `CSG_L1_LO) && (a <= `CSG_L1_HI));
   endfunction : in_secure

   // Compares the lowest n words of two key images.
   function automatic logic low_eq(input csg_key_t a, input csg_key_t b, input int n);
      low_eq = 1'b1;
      for (int i = 0; i < `CSG_KEY_WORDS; i++) begin
         if ((i < n) && (a[i] != b[i])) begin
            low_eq = 1'b0;
         end
      end
   endfunction : low_eq

   logic all_loaded;
   logic pw_zero;
   logic lo_blank;
   logic sec_hit;

   // Match terms are only trusted once every password word was fetched,
   // otherwise a stale shadow could unlock the part.
   assign all_loaded = &state_r.loaded;
   assign pw_zero    = (state_r.pw == '0);
   assign lo_blank   = (state_r.pw[3:0] == {64{1'b1}});
   assign sec_hit    = LINK.acc_req && in_secure(LINK.acc_addr);

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------

   // All decisions for one cycle are formed here from the registered state.
   always_comb begin
      state_nxt         = state_r;
      state_nxt.pw_ack  = 1'b0;
      state_nxt.acc_ack = 1'b0;
      state_nxt.run     = 1'b1;

      // Software loads the key one 16-bit word at a time.
      if (LINK.key_wr) begin
         state_nxt.key[LINK.key_idx] = LINK.key_word;
      end

      // Password fetch with a fixed wait count, whatever the flash timing.
      case (state_r.st)
         CSG_GS_IDLE: begin
            if (LINK.pw_rd) begin
               state_nxt.st   = CSG_GS_WAIT;
               state_nxt.ws   = '0;
               state_nxt.idx  = LINK.pw_idx;
               state_nxt.rd   = 1'b1;
               state_nxt.addr = `CSG_PW_BASE + {19'h0, LINK.pw_idx};
            end
         end
         CSG_GS_WAIT: begin
            if (state_r.ws == `CSG_PW_WS) begin
               state_nxt.st                  = CSG_GS_IDLE;
               state_nxt.rd                  = 1'b0;
               state_nxt.pw[state_r.idx]     = FLASH_DATA_I;
               state_nxt.loaded[state_r.idx] = 1'b1;
               state_nxt.pw_ack              = 1'b1;
            end else begin
               state_nxt.ws = state_r.ws + 5'h01;
            end
         end
         default: begin
            state_nxt.st = CSG_GS_IDLE;
            state_nxt.rd = 1'b0;
         end
      endcase

      // A zero password can never be matched, so such a part stays locked.
      state_nxt.full = all_loaded && !pw_zero
                     && low_eq(state_r.key, state_r.pw, `CSG_KEY_WORDS);

      // Partial unlock: the low half only, or nothing if that half is blank.
      state_nxt.emu = all_loaded
                    && (lo_blank
                        || low_eq(state_r.key, state_r.pw, `CSG_LO_WORDS));

      // Every access gets an answer one cycle later.
      if (LINK.acc_req) begin
         state_nxt.acc_ack = 1'b1;
         // Secure code may always read itself; others need the full key.
         state_nxt.acc_ok  = !sec_hit || state_r.full
                           || (LINK.acc_src == CSG_SRC_SECURE);
         // The cut link also blocks any later debug-port read.
         if (state_r.trip && (LINK.acc_src == CSG_SRC_JTAG)) begin
            state_nxt.acc_ok = 1'b0;
         end
      end

      // With an emulator attached any secure touch trips, unless partly
      // unlocked; the trip is sticky until the next reset.
      if (LINK.emu_conn && sec_hit && !state_r.emu && !state_r.full) begin
         state_nxt.trip = 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------

   // Reset relocks the gate and forgets key, password shadow and trip.
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_r         <= '0;
         state_r.st      <= CSG_GS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------

   // All outputs come straight from flip-flops.
   assign FLASH_RD_O       = state_r.rd;
   assign FLASH_ADDR_O     = state_r.addr;
   assign LOCKED_O         = !state_r.full;
   assign LINK.pw_ack      = state_r.pw_ack;
   assign LINK.acc_ack     = state_r.acc_ack;
   assign LINK.acc_ok      = state_r.acc_ok;
   assign LINK.emu_cut     = state_r.trip;
   assign LINK.full_unlock = state_r.full;
   assign LINK.emu_unlock  = state_r.emu;
   // Nothing holds the processor: it starts right after reset.
   assign LINK.cpu_run     = state_r.run;

endmodule : csg_gate

// ===== core/csg_defs.svh
`ifndef CSG_DEFS_SVH
`define CSG_DEFS_SVH

// ----------------------------------------------------------------------------
// Address map of the secure region (program address, 16-bit words)
// ----------------------------------------------------------------------------
`define CSG_ADDR_W      22
`define CSG_FLASH_LO    22'h3d8000
`define CSG_FLASH_HI    22'h3f7fff
`define CSG_OTP_LO      22'h3d7800
`define CSG_OTP_HI      22'h3d7bf9
`define CSG_L0_LO       22'h008000
`define CSG_L0_HI       22'h0087ff
`define CSG_L1_LO       22'h008800
`define CSG_L1_HI       22'h008bff

// ----------------------------------------------------------------------------
// Password store and key layout
// ----------------------------------------------------------------------------
`define CSG_PW_BASE     22'h3f7ff8
`define CSG_KEY_WORDS   8
`define CSG_WORD_W      16
`define CSG_LO_WORDS    4
`define CSG_PW_WS       5'h10
`define CSG_WS_W        5
`define CSG_IDX_W       3

`endif

// ===== core/csg_pkg.sv
// ----------------------------------------------------------------------------
// Types shared by both ends of the security gate
// ----------------------------------------------------------------------------
package csg_pkg;

   // Origin of a memory access.
   typedef enum logic [1:0] {
      CSG_SRC_SECURE = 2'h0,   // Code running from inside the secure region.
      CSG_SRC_OPEN   = 2'h1,   // External memory or boot-loaded code.
      CSG_SRC_JTAG   = 2'h2    // Debug port.
   } csg_src_e;

   // Password fetch sequencer of the gate.
   typedef enum logic [1:0] {
      CSG_GS_IDLE = 2'b01,
      CSG_GS_WAIT = 2'b10
   } csg_gate_st_e;

   // Unlock sequencer of the host end.
   typedef enum logic [3:0] {
      CSG_HS_IDLE = 4'b0001,
      CSG_HS_READ = 4'b0010,
      CSG_HS_WAIT = 4'b0100,
      CSG_HS_KEY  = 4'b1000
   } csg_host_st_e;

   typedef logic [7:0][15:0] csg_key_t;

endpackage : csg_pkg

// ===== core/csg_if.sv
`timescale 1ns/10ps
`include "csg_defs.svh"

// ----------------------------------------------------------------------------
// Link between the processor/debug side and the security gate
// ----------------------------------------------------------------------------
interface csg_if;
   import csg_pkg::*;

   logic                     key_wr;
   logic [`CSG_IDX_W-1:0]    key_idx;
   logic [`CSG_WORD_W-1:0]   key_word;
   logic                     pw_rd;
   logic [`CSG_IDX_W-1:0]    pw_idx;
   logic                     pw_ack;
   logic                     acc_req;
   logic [`CSG_ADDR_W-1:0]   acc_addr;
   csg_src_e                 acc_src;
   logic                     acc_ack;
   logic                     acc_ok;
   logic                     emu_conn;
   logic                     emu_cut;
   logic                     full_unlock;
   logic                     emu_unlock;
   logic                     cpu_run;

   modport gate (input  key_wr, key_idx, key_word, pw_rd, pw_idx, acc_req, acc_addr,
                        acc_src, emu_conn,
                 output pw_ack, acc_ack, acc_ok, emu_cut, full_unlock, emu_unlock,
                        cpu_run);
   modport host (output key_wr, key_idx, key_word, pw_rd, pw_idx, acc_req, acc_addr,
                        acc_src, emu_conn,
                 input  pw_ack, acc_ack, acc_ok, emu_cut, full_unlock, emu_unlock,
                        cpu_run);
endinterface : csg_if

// ===== core/csg_host.sv
`timescale 1ns/10ps
`include "csg_defs.svh"

// ----------------------------------------------------------------------------
// Processor and debugger end: unlock sequence and access forwarding
// ----------------------------------------------------------------------------
module csg_host (
   input  wire logic                    CLOCK_I,
   input  wire logic                    RST_N_I,
   csg_if.host                          LINK,
   input  wire logic                    UNLOCK_I,
   input  wire logic                    EMU_ONLY_I,
   input  wire logic [127:0]            KEY_I,
   input  wire logic                    ACC_REQ_I,
   input  wire logic [`CSG_ADDR_W-1:0]  ACC_ADDR_I,
   input  wire csg_pkg::csg_src_e       ACC_SRC_I,
   input  wire logic                    EMU_ATTACH_I,
   output logic                         BUSY_O,
   output logic                         ACC_ACK_O,
   output logic                         ACC_OK_O,
   output logic                         EMU_CUT_O
);
   import csg_pkg::*;

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      csg_host_st_e           st;
      logic [`CSG_IDX_W-1:0]  idx;
      logic                   emu_only;
      csg_key_t               key;
      logic                   pw_rd;
      logic                   key_wr;
      logic                   emu;
   } csg_host_s;

   csg_host_s state_r;
   csg_host_s state_nxt;

   // Dummy-reads all eight password words, then writes the key words; a
   // partial unlock writes only the low four but still reads all eight.
   always_comb begin
      state_nxt        = state_r;
      state_nxt.pw_rd  = 1'b0;
      state_nxt.key_wr = 1'b0;
      // Attach only after the part has started and the gate has not cut.
      state_nxt.emu    = EMU_ATTACH_I && LINK.cpu_run && !LINK.emu_cut;
      case (state_r.st)
         CSG_HS_IDLE: begin
            if (UNLOCK_I) begin
               state_nxt.st       = CSG_HS_READ;
               state_nxt.idx      = '0;
               state_nxt.key      = KEY_I;
               state_nxt.emu_only = EMU_ONLY_I;
            end
         end
         CSG_HS_READ: begin
            state_nxt.pw_rd = 1'b1;
            state_nxt.st    = CSG_HS_WAIT;
         end
         CSG_HS_WAIT: begin
            if (LINK.pw_ack) begin
               state_nxt.idx = state_r.idx + 3'h1;
               state_nxt.st  = (state_r.idx == 3'h7) ? CSG_HS_KEY : CSG_HS_READ;
            end
         end
         CSG_HS_KEY: begin
            state_nxt.key_wr = 1'b1;
            state_nxt.idx    = state_r.idx + 3'h1;
            if ((state_r.idx == 3'h7)
                || (state_r.emu_only && (state_r.idx == 3'h3))) begin
               state_nxt.st = CSG_HS_IDLE;
            end
         end
         default: begin
            state_nxt.st = CSG_HS_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_r    <= '0;
         state_r.st <= CSG_HS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The key word written is the one the index pointed at before it advanced.
   assign LINK.key_wr   = state_r.key_wr;
   assign LINK.key_idx  = state_r.idx - 3'h1;
   assign LINK.key_word = state_r.key[LINK.key_idx];
   assign LINK.pw_rd    = state_r.pw_rd;
   assign LINK.pw_idx   = state_r.idx;
   assign LINK.acc_req  = ACC_REQ_I;
   assign LINK.acc_addr = ACC_ADDR_I;
   assign LINK.acc_src  = ACC_SRC_I;
   assign LINK.emu_conn = state_r.emu;
   assign BUSY_O        = (state_r.st != CSG_HS_IDLE);
   assign ACC_ACK_O     = LINK.acc_ack;
   assign ACC_OK_O      = LINK.acc_ok;
   assign EMU_CUT_O     = LINK.emu_cut;

endmodule : csg_host

// ===== tb/csg_link_monitor.sv
`timescale 1ns/10ps
`include "csg_defs.svh"

// ----------------------------------------------------------------------------
// Watcher of the link between the host end and the gate end
// ----------------------------------------------------------------------------
module csg_link_monitor
   import csg_pkg::*;
(
   input wire logic                     CLOCK_I,
   input wire logic                     RST_N_I,
   input wire logic                     pw_rd,
   input wire logic                     pw_ack,
   input wire logic                     acc_req,
   input wire logic [`CSG_ADDR_W-1:0]   acc_addr,
   input wire csg_src_e                 acc_src,
   input wire logic                     acc_ack,
   input wire logic                     acc_ok,
   input wire logic                     emu_conn,
   input wire logic                     emu_cut,
   input wire logic                     full_unlock,
   input wire logic                     emu_unlock,
   input wire logic                     cpu_run
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   // Region decode kept apart from the design so a wrong bound shows up.
   logic hit;
   assign hit = (acc_addr >= `CSG_FLASH_LO && acc_addr <= `CSG_FLASH_HI) ||
                (acc_addr >= `CSG_OTP_LO && acc_addr <= `CSG_OTP_HI) ||
                (acc_addr >= `CSG_L0_LO && acc_addr <= `CSG_L1_HI);

   property p_pw_lat; pw_ack |-> $past(pw_rd, 18); endproperty
   a_pw_lat: assert property (p_pw_lat)
      else $error("password answer not 18 cycles after its fetch");
   property p_pw_quiet; pw_rd |-> ##1 !pw_ack [*8]; endproperty
   a_pw_quiet: assert property (p_pw_quiet)
      else $error("password answer came early");
   property p_ack; acc_req |=> acc_ack; endproperty
   a_ack: assert property (p_ack)
      else $error("access not answered after one cycle");
   property p_ack_src; acc_ack |-> $past(acc_req); endproperty
   a_ack_src: assert property (p_ack_src)
      else $error("access answer without request");
   property p_jtag; acc_req && acc_src == CSG_SRC_JTAG && hit && !full_unlock |=> !acc_ok;
   endproperty
   a_jtag: assert property (p_jtag)
      else $error("locked debug read of secure memory granted");
   property p_inside; acc_req && acc_src == CSG_SRC_SECURE |=> acc_ok; endproperty
   a_inside: assert property (p_inside)
      else $error("access by secure code refused");
   property p_open; acc_req && !hit && acc_src != CSG_SRC_JTAG |=> acc_ok; endproperty
   a_open: assert property (p_open)
      else $error("access outside the region refused");
   property p_trip; emu_conn && acc_req && hit && !emu_unlock && !full_unlock |=> emu_cut;
   endproperty
   a_trip: assert property (p_trip)
      else $error("emulator touch of secure memory did not trip");
   property p_sticky; emu_cut |=> emu_cut; endproperty
   a_sticky: assert property (p_sticky)
      else $error("trip cleared without reset");
   property p_conn; emu_cut |-> ##1 !emu_conn; endproperty
   a_conn: assert property (p_conn)
      else $error("emulator link kept after trip");
   property p_full_emu; full_unlock |-> emu_unlock; endproperty
   a_full_emu: assert property (p_full_emu)
      else $error("full unlock without emulation unlock");
   property p_run; !cpu_run |=> cpu_run; endproperty
   a_run: assert property (p_run)
      else $error("processor not running after reset");
endmodule : csg_link_monitor

// ===== tb/tb.sv
`timescale 1ns/10ps
`include "csg_defs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] t=%0t got %0h expected %0h", $time, got, exp); end end

module tb;
   import csg_pkg::*;
   localparam logic [127:0] PW = 128'h8e71_5a3c_19f2_c4d7_7b06_2e95_d1a8_63bf;
   logic        clk = 1'b0, rst_n = 1'b0, unlock = 1'b0, emu_only = 1'b0;
   logic        acc_req = 1'b0, attach = 1'b0, flash_rd, locked, busy, ack, ok, cut;
   logic [127:0] key = 128'h0;
   logic [21:0]  addr = 22'h0, flash_addr;
   logic [15:0]  flash_data;
   csg_src_e     src = CSG_SRC_SECURE;
   csg_key_t     pw = PW;
   int           bad_count = 0, n_compared = 0;
   logic [21:0]  sec_a [6] = '{22'h3d8000, 22'h3f7fff, 22'h3d7800, 22'h3d7bf9, 22'h008000,
                              22'h008bff};

   csg_if link ();

   // Clock of 8 ns.
   always #4 clk = ~clk;

   // Flash word; outside a fetch the inverse shows, so stale data cannot pass.
   assign flash_data = flash_rd ? pw[flash_addr[2:0]] : ~pw[flash_addr[2:0]];

   csg_gate i_csg_gate (.CLOCK_I(clk), .RST_N_I(rst_n), .LINK(link), .FLASH_RD_O(flash_rd),
      .FLASH_ADDR_O(flash_addr), .FLASH_DATA_I(flash_data), .LOCKED_O(locked));
   csg_host i_csg_host (.CLOCK_I(clk), .RST_N_I(rst_n), .LINK(link), .UNLOCK_I(unlock),
      .EMU_ONLY_I(emu_only), .KEY_I(key), .ACC_REQ_I(acc_req), .ACC_ADDR_I(addr),
      .ACC_SRC_I(src), .EMU_ATTACH_I(attach), .BUSY_O(busy), .ACC_ACK_O(ack),
      .ACC_OK_O(ok), .EMU_CUT_O(cut));
   csg_link_monitor i_csg_link_monitor (.CLOCK_I(clk), .RST_N_I(rst_n), .pw_rd(link.pw_rd),
      .pw_ack(link.pw_ack), .acc_req(link.acc_req), .acc_addr(link.acc_addr),
      .acc_src(link.acc_src), .acc_ack(link.acc_ack), .acc_ok(link.acc_ok),
      .emu_conn(link.emu_conn), .emu_cut(link.emu_cut), .full_unlock(link.full_unlock),
      .emu_unlock(link.emu_unlock), .cpu_run(link.cpu_run));

   // ---------------------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------------------
   task automatic access(input logic [21:0] a, input csg_src_e s, input logic exp);
      int i;
      @(posedge clk);
      acc_req <= 1'b1;
      addr    <= a;
      src     <= s;
      @(posedge clk);
      acc_req <= 1'b0;
      #1;
      i = 0;
      while (ack !== 1'b1 && i < 4) begin
         @(posedge clk);
         #1;
         i++;
      end
      `CHK(ack, 1'b1)
      `CHK(ok, exp)
   endtask : access

   // The whole sequence takes some 160 cycles, so the wait is bounded at 500.
   task automatic do_unlock(input logic [127:0] k, input logic e);
      int i;
      @(posedge clk);
      unlock   <= 1'b1;
      emu_only <= e;
      key      <= k;
      @(posedge clk);
      unlock <= 1'b0;
      #1;
      i = 0;
      while (busy !== 1'b0 && i < 500) begin
         @(posedge clk);
         #1;
         i++;
      end
      `CHK(busy, 1'b0)
      repeat (3) @(posedge clk);
      #1;
   endtask : do_unlock

   task automatic do_reset(input logic [127:0] p);
      @(posedge clk);
      rst_n <= 1'b0;
      pw    <= p;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(locked, 1'b1)
      `CHK(link.full_unlock, 1'b0)
      `CHK(link.emu_unlock, 1'b0)
   endtask : do_reset

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // Main sequence of tests.
   initial begin
      do_reset(PW);
      foreach (sec_a[i]) access(sec_a[i], CSG_SRC_JTAG, 1'b0);
      access(22'h3f7ff0, CSG_SRC_OPEN, 1'b0);
      access(22'h3f7ff5, CSG_SRC_OPEN, 1'b0);
      access(22'h3f7ff0, CSG_SRC_SECURE, 1'b1);
      access(22'h3d7bfa, CSG_SRC_JTAG, 1'b1);
      access(22'h3d7bfa, CSG_SRC_OPEN, 1'b1);
      access(22'h008400, CSG_SRC_SECURE, 1'b1);
      $display("test locked done");
      do_unlock({~PW[127:112], PW[111:0]}, 1'b0);
      `CHK(locked, 1'b1)
      `CHK(link.emu_unlock, 1'b1)
      $display("test wrong key done");
      do_reset(PW);
      do_unlock({64'h0, PW[63:0]}, 1'b1);
      `CHK(link.emu_unlock, 1'b1)
      `CHK(locked, 1'b1)
      @(posedge clk);
      attach <= 1'b1;
      access(22'h3d8000, CSG_SRC_JTAG, 1'b0);
      access(22'h3d8000, CSG_SRC_SECURE, 1'b1);
      `CHK(cut, 1'b0)
      do_unlock(PW, 1'b0);
      `CHK(locked, 1'b0)
      access(22'h3f7fff, CSG_SRC_JTAG, 1'b1);
      $display("test unlock done");
      // The emulator stays attached across reset, so the trip test starts at once.
      do_reset(PW);
      repeat (3) @(posedge clk);
      access(22'h3d8000, CSG_SRC_SECURE, 1'b1);
      `CHK(cut, 1'b1)
      access(22'h3d7bfa, CSG_SRC_JTAG, 1'b0);
      @(posedge clk);
      attach <= 1'b0;
      $display("test trip done");
      do_reset({PW[127:64], 64'hffff_ffff_ffff_ffff});
      `CHK(cut, 1'b0)
      do_unlock(128'h0, 1'b1);
      `CHK(link.emu_unlock, 1'b1)
      `CHK(locked, 1'b1)
      $display("test blank done");
      do_reset(128'h0);
      do_unlock(128'h0, 1'b0);
      `CHK(locked, 1'b1)
      $display("test zero password done");
      print_verdict();
   end

   // Watchdog well beyond the expected run of about 1,000 cycles.
   initial begin
      #400000;
      bad_count++;
      $display("[ERR] t=%0t watchdog expired", $time);
      print_verdict();
   end
endmodule : tb
